/* sbr_frame_model.sv */
// Shifter stand-in: reports a frame end after ten bit enables
`timescale 1ns/1ps
`default_nettype none
module sbr_frame_model
  import sbr_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Bit enables and frame commands
  input wire sbr_rate_t i_rate,
  input wire logic i_go_tx,
  input wire logic i_go_rx,
  input wire logic i_ninth,
  input wire logic i_stop,
  // Frame events
  output sbr_frame_evt_t o_evt
);
  int tx_left = 0;
  int rx_left = 0;
  wire rx_end = i_rate.rx_bit && rx_left == 1;
  // Count bit times; status bits hold the inverse outside a frame end
  always_ff @(posedge i_clk) begin
    o_evt.tx_done <= i_rate.tx_bit && tx_left == 1;
    o_evt.rx_done <= rx_end;
    o_evt.rx_ninth <= rx_end ? i_ninth : !i_ninth;
    o_evt.rx_stop <= rx_end ? i_stop : !i_stop;
    if (i_go_tx)
      tx_left <= 10;
    else if (i_rate.tx_bit && tx_left > 0)
      tx_left <= tx_left - 1;
    if (i_go_rx)
      rx_left <= 10;
    else if (i_rate.rx_bit && rx_left > 0)
      rx_left <= rx_left - 1;
  end
endmodule : sbr_frame_model
`default_nettype wire

/* sbr_pkg.sv */
// Shared constants and carrier types for the serial bit-rate block
package sbr_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] SBR_ADDR_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] SBR_ADDR_POWER_CONTROL = 8'h04;
  localparam logic [7:0] SBR_ADDR_TIMER_MODE = 8'h08;
  localparam logic [7:0] SBR_ADDR_T1_LOW = 8'h0c;
  localparam logic [7:0] SBR_ADDR_T1_RELOAD = 8'h10;
  localparam logic [7:0] SBR_ADDR_T1_CONTROL = 8'h14;
  localparam logic [7:0] SBR_ADDR_T2_CONTROL = 8'h18;
  localparam logic [7:0] SBR_ADDR_T2_LOW = 8'h1c;
  localparam logic [7:0] SBR_ADDR_T2_HIGH = 8'h20;
  localparam logic [7:0] SBR_ADDR_RELOAD_LOW = 8'h24;
  localparam logic [7:0] SBR_ADDR_RELOAD_HIGH = 8'h28;

  // Serial control/status field positions
  localparam int SBR_SCS_MODE_HI = 7;
  localparam int SBR_SCS_MODE_LO = 6;
  localparam int SBR_SCS_QUALIFY = 5;
  localparam int SBR_SCS_RX_ENABLE = 4;
  localparam int SBR_SCS_TX_NINTH = 3;
  localparam int SBR_SCS_RX_NINTH = 2;
  localparam int SBR_SCS_TX_DONE = 1;
  localparam int SBR_SCS_RX_DONE = 0;

  // Power control: rate doubling bit position
  localparam int SBR_PCR_DOUBLE = 7;

  // Timer mode register: timer one nibble positions
  localparam int SBR_TMR_T1_SOURCE = 6;
  localparam int SBR_TMR_T1_MODE_HI = 5;
  localparam int SBR_TMR_T1_MODE_LO = 4;

  // Timer one control: run bit position
  localparam int SBR_T1C_RUN = 0;

  // Timer two control field positions
  localparam int SBR_T2C_OVF = 7;
  localparam int SBR_T2C_EXT_FLAG = 6;
  localparam int SBR_T2C_RX_SEL = 5;
  localparam int SBR_T2C_TX_SEL = 4;
  localparam int SBR_T2C_EXT_EN = 3;
  localparam int SBR_T2C_RUN = 2;
  localparam int SBR_T2C_SOURCE = 1;

  // Reset values
  localparam logic [7:0] SBR_RST_BYTE = 8'h00;

  // Divider counts in oscillator cycles; the over-16 count is in timer overflows
  localparam logic [3:0] SBR_MACHINE_LAST = 4'hb;
  localparam logic [4:0] SBR_DIV32_LAST = 5'h1f;
  localparam logic [3:0] SBR_DIV16_LAST = 4'hf;

  // Serial port modes
  typedef enum logic [1:0] {
    SBR_MODE_SHIFT = 2'h0,
    SBR_MODE_8BIT = 2'h1,
    SBR_MODE_9FIXED = 2'h2,
    SBR_MODE_9VAR = 2'h3
  } sbr_mode_t;

  // Timer one running modes
  localparam logic [1:0] SBR_T1_13BIT = 2'h0;
  localparam logic [1:0] SBR_T1_16BIT = 2'h1;
  localparam logic [1:0] SBR_T1_AUTO8 = 2'h2;

  // Frame events from the neighbouring shifter
  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic rx_ninth;
    logic rx_stop;
  } sbr_frame_evt_t;

  // Bit-clock enables towards the shifter
  typedef struct packed {
    logic tx_bit;
    logic rx_bit;
  } sbr_rate_t;

  // Static port settings towards the shifter
  typedef struct packed {
    sbr_mode_t mode;
    logic rx_enable;
    logic tx_ninth;
  } sbr_port_cfg_t;

endpackage : sbr_pkg

/* sbr_rate_ctrl.sv */
// Serial port bit-rate generator with control and status registers
//
// Notes on behaviour
// RULE_01 - Shift-register mode bit rate is oscillator over 12, no timer.
// RULE_02 - Fixed 9-bit mode: oscillator over 64, or over 32 when doubled.
// RULE_03 - Reset clears the rate doubling bit.
// RULE_04 - Timer one rate: overflow rate times doubling factor over 32.
// RULE_05 - Timer one may count cycles or pin events in three modes.
// RULE_06 - Software normally uses timer one 8-bit auto-reload mode.
// RULE_07 - Software keeps timer one interrupt off while it sets the rate.
// RULE_08 - Very low rates: 16-bit timer one reloaded by software.
// RULE_09 - Either timer two select bit enters baud mode; directions differ.
// RULE_10 - Timer two baud behaviour holds only while a select bit is set.
// RULE_11 - Baud mode: each high byte rollover reloads from reload bytes.
// RULE_12 - Timer two source: bit rate is its overflow rate over 16.
// RULE_13 - Baud mode timer two counts every state time, oscillator over 2.
// RULE_14 - Timer two rate: oscillator over 32 times 65536 minus reload.
// RULE_15 - Baud mode rollover sets no overflow flag and no interrupt.
// RULE_16 - Baud mode external edge sets its flag but does not reload.
// RULE_17 - Software leaves running timer two and reload bytes alone.
// RULE_18 - Transmit done set at frame end; only software clears it.
// RULE_19 - Receive done set at frame end, subject to qualify bit.
// RULE_20 - Mode 1 with qualify set needs a valid stop bit.
// RULE_21 - Software keeps qualify bit clear in shift-register mode.
// RULE_22 - 9-bit modes with qualify set need received ninth bit 1.
// RULE_23 - Separate transmit and receive bit enables, each own source.
`timescale 1ns/1ps
`default_nettype none
module sbr_rate_ctrl
  import sbr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // External pins: timer one count, timer two count, timer two edge
  input wire logic i_timer_one_pin,
  input wire logic i_timer_two_pin,
  input wire logic i_timer_two_external_pin,
  // Frame events from the shifter
  input wire sbr_frame_evt_t i_frame_evt,
  // Towards the shifter
  output sbr_rate_t o_rate,
  output sbr_port_cfg_t o_port_cfg
);

  // Software-visible registers
  logic [7:0] serial_control_status;
  logic [7:0] power_control_register;
  logic [7:0] timer_mode_register;
  logic [7:0] timer_one_low_byte;
  logic [7:0] timer_one_reload_byte;
  logic [7:0] timer_one_control;
  logic [7:0] timer_two_control;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;

  // Dividers and prescalers
  logic [3:0] machine_phase;
  logic [5:0] fixed_div;
  logic [4:0] t1_ovf_div;
  logic [3:0] t2_ovf_div;

  // Pin synchronisers and edge history
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;

  // APB answer and output flops
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sbr_rate_t rate;
  sbr_port_cfg_t port_cfg;

  // Bus decode
  logic apb_setup;
  logic apb_write;
  logic hit_scs;
  logic hit_pcr;
  logic hit_tmr;
  logic hit_t1l;
  logic hit_t1h;
  logic hit_t1c;
  logic hit_t2c;
  logic hit_t2l;
  logic hit_t2h;
  logic hit_rcl;
  logic hit_rch;
  logic addr_mapped;
  logic [7:0] wbyte;
  logic [7:0] read_byte;

  // Decoded controls
  sbr_mode_t mode;
  logic rate_double;
  logic [1:0] t1_mode;
  logic t1_from_pin;
  logic t1_run;
  logic t2_baud;
  logic t2_tx_sel;
  logic t2_rx_sel;
  logic t2_from_pin;
  logic t2_run;
  logic t2_ext_en;

  // Time bases
  logic machine_tick;
  logic state_tick;
  logic fixed_tick;
  logic [2:0] pin_fall;

  // Timer one
  logic t1_count;
  logic [16:0] t1_sum16;
  logic [13:0] t1_sum13;
  logic [8:0] t1_sum8;
  logic t1_ovf;
  logic [7:0] next_t1_low;
  logic [7:0] next_t1_high;
  logic t1_tick;

  // Timer two
  logic t2_count;
  logic t2_ext_edge;
  logic [15:0] t2_value;
  logic t2_rollover;
  logic t2_tick;

  // Flags and next values
  logic rx_accept;
  logic [7:0] next_scs;
  logic [7:0] next_t2c;
  logic next_tx_bit;
  logic next_rx_bit;

  // APB decode: answer in the cycle after setup
  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && pready && i_pwrite;
  assign wbyte = i_pwdata[7:0];
  assign hit_scs = (i_paddr == SBR_ADDR_CONTROL_STATUS);
  assign hit_pcr = (i_paddr == SBR_ADDR_POWER_CONTROL);
  assign hit_tmr = (i_paddr == SBR_ADDR_TIMER_MODE);
  assign hit_t1l = (i_paddr == SBR_ADDR_T1_LOW);
  assign hit_t1h = (i_paddr == SBR_ADDR_T1_RELOAD);
  assign hit_t1c = (i_paddr == SBR_ADDR_T1_CONTROL);
  assign hit_t2c = (i_paddr == SBR_ADDR_T2_CONTROL);
  assign hit_t2l = (i_paddr == SBR_ADDR_T2_LOW);
  assign hit_t2h = (i_paddr == SBR_ADDR_T2_HIGH);
  assign hit_rcl = (i_paddr == SBR_ADDR_RELOAD_LOW);
  assign hit_rch = (i_paddr == SBR_ADDR_RELOAD_HIGH);
  assign addr_mapped = hit_scs || hit_pcr || hit_tmr || hit_t1l ||
                       hit_t1h || hit_t1c || hit_t2c || hit_t2l ||
                       hit_t2h || hit_rcl || hit_rch;

  // Read selection; timer two bytes show the live count
  assign read_byte =
    hit_scs ? serial_control_status :
    hit_pcr ? power_control_register :
    hit_tmr ? timer_mode_register :
    hit_t1l ? timer_one_low_byte :
    hit_t1h ? timer_one_reload_byte :
    hit_t1c ? timer_one_control :
    hit_t2c ? timer_two_control :
    hit_t2l ? t2_value[7:0] :
    hit_t2h ? t2_value[15:8] :
    hit_rcl ? reload_low_byte :
    hit_rch ? reload_high_byte : SBR_RST_BYTE;

  // Control field views
  assign mode = sbr_mode_t'(serial_control_status[SBR_SCS_MODE_HI:
                                                 SBR_SCS_MODE_LO]);
  assign rate_double = power_control_register[SBR_PCR_DOUBLE];
  assign t1_mode = timer_mode_register[SBR_TMR_T1_MODE_HI:
                                       SBR_TMR_T1_MODE_LO];
  assign t1_from_pin = timer_mode_register[SBR_TMR_T1_SOURCE];
  assign t1_run = timer_one_control[SBR_T1C_RUN];
  assign t2_tx_sel = timer_two_control[SBR_T2C_TX_SEL];
  assign t2_rx_sel = timer_two_control[SBR_T2C_RX_SEL];
  assign t2_baud = t2_tx_sel || t2_rx_sel; // [RULE_09] [RULE_10]
  assign t2_from_pin = timer_two_control[SBR_T2C_SOURCE];
  assign t2_run = timer_two_control[SBR_T2C_RUN];
  assign t2_ext_en = timer_two_control[SBR_T2C_EXT_EN];

  // Machine cycle is twelve oscillator cycles, state time two
  assign machine_tick = (machine_phase == SBR_MACHINE_LAST);
  assign state_tick = machine_phase[0]; // [RULE_13]

  // Fixed divider: over 64, or over 32 when doubled
  assign fixed_tick = (fixed_div[4:0] == SBR_DIV32_LAST) &&
                      (rate_double || fixed_div[5]); // [RULE_02]

  // Falling edges compare the second synchroniser stage with the edge history
  assign pin_fall = pin_last & ~pin_sync;

  // Timer one counts cycles or pin events, gated by run
  assign t1_count = t1_run &&
                    (t1_from_pin ? pin_fall[0] : machine_tick); // [RULE_05]
  assign t1_sum16 = {1'b0, timer_one_reload_byte, timer_one_low_byte} +
                    17'h00001;
  assign t1_sum13 = {1'b0, timer_one_reload_byte, timer_one_low_byte[4:0]} +
                    14'h0001;
  assign t1_sum8 = {1'b0, timer_one_low_byte} + 9'h001;

  // Timer one next state per running mode; mode 3 holds
  always_comb begin
    next_t1_low = timer_one_low_byte;
    next_t1_high = timer_one_reload_byte;
    t1_ovf = 1'b0;
    if (t1_count) begin
      case (t1_mode)
        SBR_T1_13BIT: begin
          next_t1_low = {3'h0, t1_sum13[4:0]};
          next_t1_high = t1_sum13[12:5];
          t1_ovf = t1_sum13[13];
        end
        SBR_T1_16BIT: begin
          next_t1_low = t1_sum16[7:0];
          next_t1_high = t1_sum16[15:8];
          t1_ovf = t1_sum16[16];
        end
        SBR_T1_AUTO8: begin
          next_t1_low = t1_sum8[8] ? timer_one_reload_byte : t1_sum8[7:0];
          t1_ovf = t1_sum8[8];
        end
        default: begin
          t1_ovf = 1'b0;
        end
      endcase
    end
    if (apb_write && hit_t1l) begin
      next_t1_low = wbyte;
    end
    if (apb_write && hit_t1h) begin
      next_t1_high = wbyte;
    end
  end

  // Timer one overflows scaled by 32, or 16 when doubled
  assign t1_tick = t1_ovf && (t1_ovf_div[3:0] == SBR_DIV16_LAST) &&
                   (rate_double || t1_ovf_div[4]); // [RULE_04]

  // Timer two: pin falls when its source bit is set, else state time in baud mode, machine cycle otherwise
  assign t2_count = t2_run && (t2_from_pin ? pin_fall[1] :
                    (t2_baud ? state_tick : machine_tick)); // [RULE_13]
  assign t2_ext_edge = t2_ext_en && pin_fall[2];

  // Overflow rate over 16 gives oscillator over 32(65536-reload)
  assign t2_tick = t2_rollover &&
                   (t2_ovf_div == SBR_DIV16_LAST); // [RULE_12] [RULE_14]

  // Per-direction source selection
  always_comb begin
    case (mode)
      SBR_MODE_SHIFT: begin
        next_tx_bit = machine_tick; // [RULE_01]
        next_rx_bit = machine_tick; // [RULE_01]
      end
      SBR_MODE_9FIXED: begin
        next_tx_bit = fixed_tick; // [RULE_02]
        next_rx_bit = fixed_tick; // [RULE_02]
      end
      default: begin
        next_tx_bit = t2_tx_sel ? t2_tick : t1_tick; // [RULE_23]
        next_rx_bit = t2_rx_sel ? t2_tick : t1_tick; // [RULE_23]
      end
    endcase
  end

  // Receive qualification by mode and qualify bit
  assign rx_accept = i_frame_evt.rx_done &&
    (!serial_control_status[SBR_SCS_QUALIFY] ||
     (mode == SBR_MODE_SHIFT) ||
     ((mode == SBR_MODE_8BIT) && i_frame_evt.rx_stop) || // [RULE_20]
     ((mode[1]) && i_frame_evt.rx_ninth)); // [RULE_19] [RULE_22]

  // Control/status next value: hardware set wins over software clear
  always_comb begin
    next_scs = serial_control_status;
    if (apb_write && hit_scs) begin
      next_scs = wbyte;
    end
    if (rx_accept) begin
      next_scs[SBR_SCS_RX_DONE] = 1'b1; // [RULE_19]
      next_scs[SBR_SCS_RX_NINTH] = mode[1] ? i_frame_evt.rx_ninth :
                                   i_frame_evt.rx_stop;
    end
    if (i_frame_evt.tx_done) begin
      next_scs[SBR_SCS_TX_DONE] = 1'b1; // [RULE_18]
    end
  end

  // Timer two control next value with hardware-set flags
  always_comb begin
    next_t2c = timer_two_control;
    if (apb_write && hit_t2c) begin
      next_t2c = wbyte;
    end
    if (t2_rollover && !t2_baud) begin
      next_t2c[SBR_T2C_OVF] = 1'b1; // [RULE_15]
    end
    if (t2_ext_edge) begin
      next_t2c[SBR_T2C_EXT_FLAG] = 1'b1; // [RULE_16]
    end
  end

  // Timer two counter; external reload only outside baud mode
  sbr_reload_timer u_timer_two (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_count(t2_count),
    .i_ext_reload(t2_ext_edge && !t2_baud), // [RULE_16]
    .i_reload({reload_high_byte, reload_low_byte}), // [RULE_11]
    .i_wr_low(apb_write && hit_t2l),
    .i_wr_high(apb_write && hit_t2h),
    .i_wdata(wbyte),
    .o_count(t2_value),
    .o_rollover(t2_rollover)
  );

  // Pin synchronisers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_last <= 3'h7;
    end else begin
      pin_meta <= {i_timer_two_external_pin, i_timer_two_pin,
                   i_timer_one_pin};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Time-base dividers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      machine_phase <= 4'h0;
      fixed_div <= 6'h00;
    end else begin
      machine_phase <= machine_tick ? 4'h0 : machine_phase + 4'h1;
      fixed_div <= fixed_div + 6'h01;
    end
  end

  // Overflow prescalers for the variable rates
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      t1_ovf_div <= 5'h00;
      t2_ovf_div <= 4'h0;
    end else begin
      t1_ovf_div <= t1_ovf ? t1_ovf_div + 5'h01 : t1_ovf_div;
      t2_ovf_div <= t2_rollover ? t2_ovf_div + 4'h1 : t2_ovf_div;
    end
  end

  // Control and status registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      serial_control_status <= SBR_RST_BYTE;
      timer_two_control <= SBR_RST_BYTE;
      timer_one_low_byte <= SBR_RST_BYTE;
      timer_one_reload_byte <= SBR_RST_BYTE;
    end else begin
      serial_control_status <= next_scs;
      timer_two_control <= next_t2c;
      timer_one_low_byte <= next_t1_low;
      timer_one_reload_byte <= next_t1_high;
    end
  end

  // Plain software-written registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      power_control_register <= SBR_RST_BYTE; // [RULE_03]
      timer_mode_register <= SBR_RST_BYTE;
      timer_one_control <= SBR_RST_BYTE;
      reload_low_byte <= SBR_RST_BYTE;
      reload_high_byte <= SBR_RST_BYTE;
    end else if (apb_write) begin
      if (hit_pcr) power_control_register <= wbyte;
      if (hit_tmr) timer_mode_register <= wbyte;
      if (hit_t1c) timer_one_control <= wbyte;
      if (hit_rcl) reload_low_byte <= wbyte;
      if (hit_rch) reload_high_byte <= wbyte;
    end
  end

  // APB answer and registered outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rate <= '0;
      port_cfg <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_mapped;
      prdata <= apb_setup ? {24'h000000, read_byte} : prdata;
      rate <= '{tx_bit: next_tx_bit, rx_bit: next_rx_bit};
      port_cfg <= '{mode: sbr_mode_t'(next_scs[7:6]),
                    rx_enable: next_scs[SBR_SCS_RX_ENABLE],
                    tx_ninth: next_scs[SBR_SCS_TX_NINTH]};
    end
  end

  assign o_prdata = prdata;
  assign o_pready = pready;
  assign o_pslverr = pslverr;
  assign o_rate = rate;
  assign o_port_cfg = port_cfg;

endmodule : sbr_rate_ctrl
`default_nettype wire

/* sbr_rate_ctrl_props.sv */
// Port checker for the serial bit-rate block
`timescale 1ns/1ps
`default_nettype none
module sbr_rate_ctrl_props
  import sbr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Shifter side
  input wire sbr_frame_evt_t i_frame_evt,
  input wire sbr_rate_t o_rate,
  input wire sbr_port_cfg_t o_port_cfg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [4:0] gap;
  logic m0run;
  logic tx_pend;
  // Decodes of mode and bus phases
  wire shift = o_port_cfg.mode == SBR_MODE_SHIFT;
  wire mapped = i_paddr[1:0] == 2'h0 && i_paddr <= 8'h28;
  wire acc0 = o_pready && i_penable && i_paddr == 8'h00;
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  // Cycles since the last transmit enable, shift mode seen, transmit flag
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap <= 5'h00;
      m0run <= 1'b0;
      tx_pend <= 1'b0;
    end else begin
      gap <= o_rate.tx_bit ? 5'h00 : gap + 5'h01;
      m0run <= shift && (m0run || o_rate.tx_bit);
      tx_pend <= i_frame_evt.tx_done ||
                 (acc0 && i_pwrite ? i_pwdata[1] : tx_pend);
    end
  end
  a_ready_after_setup: assert property (s_setup |=> o_pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  a_err_decode: assert property (s_setup |=> o_pslverr == !$past(mapped))
    else $error("wrong error response");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_rdata_upper: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read data set");
  a_shift_period: assert property (
    m0run && shift |-> o_rate.tx_bit == (gap == 5'h0b))
    else $error("shift mode period wrong");
  a_shift_rx_tx: assert property (
    m0run && shift |-> o_rate.rx_bit == o_rate.tx_bit)
    else $error("shift mode enables differ");
  a_cfg_mirror: assert property (acc0 && i_pwrite |-> ##2 o_port_cfg ==
    {$past(i_pwdata[7:6], 2), $past(i_pwdata[4], 2), $past(i_pwdata[3], 2)})
    else $error("port settings not mirrored");
  a_tx_flag_read: assert property (
    acc0 && !i_pwrite && $past(tx_pend) |-> o_prdata[1])
    else $error("transmit flag not read");
endmodule : sbr_rate_ctrl_props
`default_nettype wire

/* sbr_reload_timer.sv */
// Sixteen-bit reloading counter used as timer two
`timescale 1ns/1ps
`default_nettype none
module sbr_reload_timer
  import sbr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Counting and reload control
  input wire logic i_count,
  input wire logic i_ext_reload,
  input wire logic [15:0] i_reload,
  // Software byte writes
  input wire logic i_wr_low,
  input wire logic i_wr_high,
  input wire logic [7:0] i_wdata,
  // Counter state
  output logic [15:0] o_count,
  output logic o_rollover
);

  logic [15:0] count;
  logic rollover;
  logic [15:0] next_count;
  logic wrap;

  // Rollover when the high byte wraps on a counting step
  assign wrap = i_count && (count == 16'hffff);

  // Software write, then reload, then plain increment
  always_comb begin
    next_count = count;
    if (i_wr_low) begin
      next_count[7:0] = i_wdata;
    end
    if (i_wr_high) begin
      next_count[15:8] = i_wdata;
    end
    if (wrap || i_ext_reload) begin
      next_count = i_reload;
    end else if (i_count) begin
      next_count = count + 16'h0001;
    end
  end

  // Counter and one-cycle rollover pulse
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= 16'h0000;
      rollover <= 1'b0;
    end else begin
      count <= next_count;
      rollover <= wrap;
    end
  end

  assign o_count = count;
  assign o_rollover = rollover;

endmodule : sbr_reload_timer
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the serial bit-rate block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sbr_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ext_pin = 1'b1, t1pin = 1'b1;
  logic go_tx = 1'b0, go_rx = 1'b0, ninth = 1'b0, stop = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  sbr_frame_evt_t evt;
  sbr_rate_t rate;
  sbr_port_cfg_t cfg;
  int mismatches = 0;
  int cmp_count = 0;
  int pc = 0;
  logic [17:0] tab [6] = '{18'h06060, 18'h18081, 18'h1e0e0, 18'h2e0e5,
    18'h3a0a5, 18'h16065};
  // Clock, and a pin event every 20 clocks
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    pc <= (pc == 9) ? 0 : pc + 1;
    if (pc == 9) t1pin <= ~t1pin;
  end
  sbr_rate_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_timer_one_pin(t1pin), .i_timer_two_pin(1'b1),
    .i_timer_two_external_pin(ext_pin), .i_frame_evt(evt), .o_rate(rate),
    .o_port_cfg(cfg));
  sbr_frame_model far (.i_clk(i_clk), .i_rate(rate), .i_go_tx(go_tx),
    .i_go_rx(go_rx), .i_ninth(ninth), .i_stop(stop), .o_evt(evt));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a,
    input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    chk(nm, x, r);
  endtask : rd
  // Negedges up to the next bit enable of one direction
  task automatic nxt(input logic rx, output int n);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while ((rx ? rate.rx_bit : rate.tx_bit) !== 1'b1 && n < 5000);
  endtask : nxt
  task automatic per(input string nm, input logic rx, input int x);
    int n;
    nxt(rx, n);
    nxt(rx, n);
    nxt(rx, n);
    chk(nm, x, n);
  endtask : per
  task automatic frame(input logic rx, input logic nb, input logic sb);
    int n;
    n = 0;
    @(posedge i_clk);
    go_tx <= !rx;
    go_rx <= rx;
    ninth <= nb;
    stop <= sb;
    @(posedge i_clk);
    go_tx <= 1'b0;
    go_rx <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
    end while (evt.tx_done !== 1'b1 && evt.rx_done !== 1'b1 && n < 5000);
    chk("frame end", 32'h1, {31'h0, n < 5000});
  endtask : frame
  // Watchdog
  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    for (int a = 0; a <= 'h28; a += 4) begin
      rd("reset value", a[7:0], 32'h0);
    end
    apb(1'b0, 8'h2c, 8'h00, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    per("shift tx", 1'b0, 12);
    per("shift rx", 1'b1, 12);
    wr(SBR_ADDR_CONTROL_STATUS, 8'h10);
    frame(1'b0, 1'b0, 1'b0);
    frame(1'b1, 1'b0, 1'b1);
    rd("shift flags", SBR_ADDR_CONTROL_STATUS, 32'h17);
    wr(SBR_ADDR_CONTROL_STATUS, 8'h80);
    per("mode2 slow", 1'b0, 64);
    wr(SBR_ADDR_POWER_CONTROL, 8'h80);
    per("mode2 fast", 1'b1, 32);
    wr(SBR_ADDR_TIMER_MODE, 8'h20);
    wr(SBR_ADDR_T1_RELOAD, 8'hff);
    wr(SBR_ADDR_T1_LOW, 8'hff);
    wr(SBR_ADDR_T1_CONTROL, 8'h01);
    wr(SBR_ADDR_CONTROL_STATUS, 8'h40);
    per("t1 doubled", 1'b0, 16 * 12 * (256 - 255));
    foreach (tab[i]) begin
      wr(SBR_ADDR_CONTROL_STATUS, tab[i][15:8]);
      frame(1'b1, tab[i][17], tab[i][16]);
      rd("rx flag", 8'h00, {24'h0, tab[i][7:0]});
    end
    wr(SBR_ADDR_POWER_CONTROL, 8'h00);
    wr(SBR_ADDR_T1_RELOAD, 8'hfe);
    per("t1 single", 1'b0, 32 * 12 * (256 - 254));
    wr(SBR_ADDR_TIMER_MODE, 8'h60);
    per("t1 pin", 1'b1, 32 * 20 * 2);
    wr(SBR_ADDR_RELOAD_HIGH, 8'hff);
    wr(SBR_ADDR_RELOAD_LOW, 8'hfe);
    wr(SBR_ADDR_T2_HIGH, 8'hff);
    wr(SBR_ADDR_T2_LOW, 8'hfe);
    wr(SBR_ADDR_T2_CONTROL, 8'h1c);
    per("t2 tx", 1'b0, 32 * (65536 - 65534));
    per("t1 rx", 1'b1, 32 * 20 * 2);
    @(posedge i_clk);
    ext_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    ext_pin <= 1'b1;
    per("t2 after edge", 1'b0, 64);
    rd("baud flags", SBR_ADDR_T2_CONTROL, 32'h5c);
    wr(SBR_ADDR_T2_CONTROL, 8'h04);
    per("t1 tx", 1'b0, 32 * 20 * 2);
    rd("plain flags", SBR_ADDR_T2_CONTROL, 32'h84);
    wr(SBR_ADDR_T2_CONTROL, 8'h24);
    per("t2 rx", 1'b1, 64);
    wr(SBR_ADDR_T1_CONTROL, 8'h00);
    wr(SBR_ADDR_TIMER_MODE, 8'h50);
    wr(SBR_ADDR_T1_LOW, 8'hff);
    @(negedge t1pin);
    repeat (5) @(posedge i_clk);
    wr(SBR_ADDR_T1_CONTROL, 8'h01);
    @(negedge t1pin);
    repeat (5) @(posedge i_clk);
    wr(SBR_ADDR_T1_CONTROL, 8'h00);
    rd("t1 16-bit high", SBR_ADDR_T1_RELOAD, 32'hff);
    rd("t1 16-bit low", SBR_ADDR_T1_LOW, 32'h00);
    end_of_test();
  end
endmodule : tb_top
bind sbr_rate_ctrl sbr_rate_ctrl_props u_props (.*);
`default_nettype wire
